//--- fifo_port_pkg.sv
// How it works
// - Read strobe low drives current receive byte
// - Read strobe falling edge advances receive buffer
// - Write strobe falling edge captures bus byte
// - Transmit flag high when full; tristate in reset
// - Write by raising then lowering write strobe
// - Receive flag high when empty; tristate in reset
// - Read by lowering then raising read strobe
// - Wakeup option in suspend makes flag input
// - External wake pulse low at least 20 ms
// - Valid wake pulse raises resume request
// - Power enable low configured, high suspended
// - Pull-down option pulls inputs low in suspend
// - Active-low reset input resets the device
// - Use pull-down option when switching power
package fifo_port_pkg;
    localparam int DATA_W      = 8;
    localparam int RX_DEPTH    = 128;
    localparam int TX_DEPTH    = 256;
    localparam int RX_AW       = 7;
    localparam int TX_AW       = 8;
    localparam int CLK_MHZ     = 200;
    localparam int WAKE_MS     = 20;
    localparam int WAKE_CYCLES = WAKE_MS * 1000 * CLK_MHZ;
    localparam int WAKE_CW     = 23;
    localparam int STROBE_CYC  = 4;
    localparam int STROBE_CW   = 3;
    typedef logic [DATA_W-1:0] byte_t;
endpackage

//--- fifo_port_if.sv
`timescale 1ns/1ps
interface fifo_port_if;
    import fifo_port_pkg::*;
    byte_t dev_data_out;
    logic  dev_data_oe;
    byte_t host_data_out;
    logic  host_data_oe;
    logic  rd_n;
    logic  wr;
    logic  tx_room_n_out;
    logic  tx_room_n_oe;
    logic  rx_avail_n_out;
    logic  rx_avail_n_oe;
    logic  host_wake_out;
    logic  host_wake_oe;
    logic  configured_power_n;
    logic  reset_n;
    // Resolved wire levels: undriven inputs float high as with the pull-ups
    byte_t fifo_byte_bus;
    logic  rx_avail_n;
    logic  tx_room_n;
    assign fifo_byte_bus = dev_data_oe ? dev_data_out :
                           (host_data_oe ? host_data_out : 8'hFF);
    assign rx_avail_n = rx_avail_n_oe ? rx_avail_n_out :
                        (host_wake_oe ? host_wake_out : 1'b1);
    assign tx_room_n = tx_room_n_oe ? tx_room_n_out : 1'b1;
    modport dev (
        input  fifo_byte_bus, rd_n, wr, rx_avail_n, reset_n,
        output dev_data_out, dev_data_oe, tx_room_n_out, tx_room_n_oe,
        output rx_avail_n_out, rx_avail_n_oe, configured_power_n
    );
    modport host (
        input  fifo_byte_bus, rx_avail_n, tx_room_n, configured_power_n,
        output host_data_out, host_data_oe, rd_n, wr, host_wake_out, host_wake_oe,
        output reset_n
    );
endinterface

//--- fifo_port_dev.sv
`timescale 1ns/1ps
module fifo_port_dev (
    input  wire logic                 clk_sys_i,
    input  wire logic                 reset_i,
    fifo_port_if.dev                  port,
    input  wire fifo_port_pkg::byte_t rx_data_i,
    input  wire logic                 rx_valid_i,
    output logic                      rx_ready_o,
    output fifo_port_pkg::byte_t      tx_data_o,
    output logic                      tx_valid_o,
    input  wire logic                 tx_ready_i,
    input  wire logic                 configured_i,
    input  wire logic                 suspend_i,
    input  wire logic                 wakeup_en_i,
    input  wire logic                 pulldown_en_i,
    output logic                      resume_req_o,
    output logic                      pulldown_o
);
    import fifo_port_pkg::*;

    byte_t             rx_mem [RX_DEPTH];
    byte_t             tx_mem [TX_DEPTH];
    logic [RX_AW:0]    rx_wp_r, rx_rp_r;
    logic [TX_AW:0]    tx_wp_r, tx_rp_r;
    logic              rd_n_r, wr_r;
    logic              in_reset;
    logic              rx_empty, tx_full, rd_fall, wr_fall, sleeping, wake_in;
    logic [WAKE_CW-1:0] wake_cnt_r;

    // Pin reset and system reset both hold the port in reset
    assign in_reset = reset_i || !port.reset_n;
    assign rx_empty = rx_wp_r == rx_rp_r;
    assign tx_full  = (tx_wp_r[TX_AW] != tx_rp_r[TX_AW]) &&
                      (tx_wp_r[TX_AW-1:0] == tx_rp_r[TX_AW-1:0]);
    assign rd_fall  = rd_n_r && !port.rd_n;
    assign wr_fall  = wr_r && !port.wr;
    assign sleeping = suspend_i && port.configured_power_n;
    assign wake_in  = wakeup_en_i && sleeping;

    // ============================================================
    // Strobe edge history
    always_ff @(posedge clk_sys_i) begin
        if (in_reset) begin
            rd_n_r <= 1'b1;
            wr_r   <= 1'b0;
        end else begin
            rd_n_r <= port.rd_n;
            wr_r   <= port.wr;
        end
    end

    // ============================================================
    // Receive buffer
    assign rx_ready_o = !in_reset &&
        !((rx_wp_r[RX_AW] != rx_rp_r[RX_AW]) &&
          (rx_wp_r[RX_AW-1:0] == rx_rp_r[RX_AW-1:0]));
    always_ff @(posedge clk_sys_i) begin
        if (in_reset) begin
            rx_wp_r <= '0;
        end else if (rx_valid_i && rx_ready_o) begin
            rx_mem[rx_wp_r[RX_AW-1:0]] <= rx_data_i;
            rx_wp_r <= rx_wp_r + 1'b1;
        end
    end
    // The pointer moves on at the falling edge, so the byte is latched there
    // and the bus keeps showing it for the whole strobe
    always_ff @(posedge clk_sys_i) begin
        if (in_reset) begin
            rx_rp_r <= '0;
        end else if (rd_fall && !rx_empty) begin
            rx_rp_r <= rx_rp_r + 1'b1;
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (in_reset) begin
            port.dev_data_out <= '0;
            port.dev_data_oe  <= 1'b0;
        end else begin
            if (rd_fall) begin
                port.dev_data_out <= rx_mem[rx_rp_r[RX_AW-1:0]];
            end
            port.dev_data_oe  <= !port.rd_n;
        end
    end

    // ============================================================
    // Transmit buffer
    always_ff @(posedge clk_sys_i) begin
        if (in_reset) begin
            tx_wp_r <= '0;
        end else if (wr_fall && !tx_full) begin
            tx_mem[tx_wp_r[TX_AW-1:0]] <= port.fifo_byte_bus;
            tx_wp_r <= tx_wp_r + 1'b1;
        end
    end
    assign tx_data_o  = tx_mem[tx_rp_r[TX_AW-1:0]];
    assign tx_valid_o = !in_reset && (tx_wp_r != tx_rp_r);
    always_ff @(posedge clk_sys_i) begin
        if (in_reset) begin
            tx_rp_r <= '0;
        end else if (tx_valid_o && tx_ready_i) begin
            tx_rp_r <= tx_rp_r + 1'b1;
        end
    end

    // ============================================================
    // Flags: released while in reset
    always_ff @(posedge clk_sys_i) begin
        if (in_reset) begin
            port.tx_room_n_out  <= 1'b1;
            port.tx_room_n_oe   <= 1'b0;
            port.rx_avail_n_out <= 1'b1;
            port.rx_avail_n_oe  <= 1'b0;
        end else begin
            port.tx_room_n_out  <= tx_full ||
                (wr_fall && (tx_wp_r + 1'b1) == {~tx_rp_r[TX_AW], tx_rp_r[TX_AW-1:0]});
            port.tx_room_n_oe   <= 1'b1;
            port.rx_avail_n_out <= rx_empty || !port.rd_n;
            port.rx_avail_n_oe  <= !wake_in;
        end
    end

    // ============================================================
    // Power, pull-downs and remote wakeup
    always_ff @(posedge clk_sys_i) begin
        if (in_reset) begin
            port.configured_power_n <= 1'b1;
            pulldown_o              <= 1'b0;
        end else begin
            port.configured_power_n <= !(configured_i && !suspend_i);
            pulldown_o              <= pulldown_en_i && sleeping;
        end
    end
    // Counting stops at the minimum so a long hold raises one request
    always_ff @(posedge clk_sys_i) begin
        if (in_reset || !wake_in || port.rx_avail_n) begin
            wake_cnt_r   <= '0;
            resume_req_o <= 1'b0;
        end else if (wake_cnt_r == WAKE_CW'(WAKE_CYCLES - 1)) begin
            wake_cnt_r   <= wake_cnt_r + 1'b1;
            resume_req_o <= 1'b1;
        end else if (wake_cnt_r < WAKE_CW'(WAKE_CYCLES - 1)) begin
            wake_cnt_r   <= wake_cnt_r + 1'b1;
            resume_req_o <= 1'b0;
        end else begin
            resume_req_o <= 1'b0;
        end
    end
endmodule

//--- fifo_port_host.sv
`timescale 1ns/1ps
module fifo_port_host (
    input  wire logic                 clk_sys_i,
    input  wire logic                 reset_i,
    fifo_port_if.host                 port,
    input  wire fifo_port_pkg::byte_t wr_data_i,
    input  wire logic                 wr_valid_i,
    output logic                      wr_ready_o,
    output fifo_port_pkg::byte_t      rd_data_o,
    output logic                      rd_valid_o,
    input  wire logic                 wake_req_i,
    input  wire logic                 dev_reset_i
);
    import fifo_port_pkg::*;

    typedef enum logic [2:0] {IDLE, RD_LOW, WR_SETUP, WR_HIGH, WR_LOW, WAKE} state_t;
    state_t             state_r;
    logic [STROBE_CW-1:0] cnt_r;
    logic [WAKE_CW-1:0]   wake_cnt_r;

    assign wr_ready_o = (state_r == IDLE) && !port.tx_room_n && !wake_req_i;

    // ============================================================
    // Strobe sequencer; one strobe at a time, never both
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            state_r            <= IDLE;
            cnt_r              <= '0;
            wake_cnt_r         <= '0;
            port.rd_n          <= 1'b1;
            port.wr            <= 1'b0;
            port.host_data_out <= '0;
            port.host_data_oe  <= 1'b0;
            port.host_wake_out <= 1'b1;
            port.host_wake_oe  <= 1'b0;
            rd_data_o          <= '0;
            rd_valid_o         <= 1'b0;
        end else begin
            rd_valid_o <= 1'b0;
            cnt_r      <= cnt_r + 1'b1;
            case (state_r)
            IDLE: begin
                cnt_r <= '0;
                if (wake_req_i && port.configured_power_n) begin
                    state_r            <= WAKE;
                    wake_cnt_r         <= '0;
                    port.host_wake_out <= 1'b0;
                    port.host_wake_oe  <= 1'b1;
                end else if (wr_valid_i && !port.tx_room_n) begin
                    state_r            <= WR_SETUP;
                    port.host_data_out <= wr_data_i;
                    port.host_data_oe  <= 1'b1;
                end else if (!port.rx_avail_n && !port.configured_power_n) begin
                    state_r   <= RD_LOW;
                    port.rd_n <= 1'b0;
                end
            end
            RD_LOW: begin
                if (cnt_r == STROBE_CW'(STROBE_CYC - 1)) begin
                    rd_data_o  <= port.fifo_byte_bus;
                    rd_valid_o <= 1'b1;
                    port.rd_n  <= 1'b1;
                    state_r    <= IDLE;
                end
            end
            WR_SETUP: begin
                port.wr <= 1'b1;
                state_r <= WR_HIGH;
                cnt_r   <= '0;
            end
            WR_HIGH: begin
                if (cnt_r == STROBE_CW'(STROBE_CYC - 1)) begin
                    port.wr <= 1'b0;
                    state_r <= WR_LOW;
                    cnt_r   <= '0;
                end
            end
            WR_LOW: begin
                // Data held past the falling edge for the capture
                if (cnt_r == STROBE_CW'(STROBE_CYC - 1)) begin
                    port.host_data_oe <= 1'b0;
                    state_r           <= IDLE;
                end
            end
            WAKE: begin
                if (wake_cnt_r == WAKE_CW'(WAKE_CYCLES)) begin
                    port.host_wake_out <= 1'b1;
                    port.host_wake_oe  <= 1'b0;
                    state_r            <= IDLE;
                end else begin
                    wake_cnt_r <= wake_cnt_r + 1'b1;
                end
            end
            default: state_r <= IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            port.reset_n <= 1'b0;
        end else begin
            port.reset_n <= !dev_reset_i;
        end
    end
endmodule

//--- fifo_port_monitor.sv
`timescale 1ns/1ps
module fifo_port_monitor (
    input wire logic                 clk_sys_i,
    input wire logic                 reset_i,
    input wire fifo_port_pkg::byte_t fifo_byte_bus,
    input wire logic                 dev_data_oe,
    input wire logic                 host_data_oe,
    input wire logic                 rd_n,
    input wire logic                 wr,
    input wire logic                 rx_avail_n,
    input wire logic                 rx_avail_n_out,
    input wire logic                 rx_avail_n_oe,
    input wire logic                 tx_room_n_oe,
    input wire logic                 reset_n
);
    import fifo_port_pkg::*;
    // ==========
    // Port timing
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i || !reset_n);
    property p_bus_drive;
        $fell(rd_n) |=> dev_data_oe;
    endproperty
    a_bus_drive: assert property (p_bus_drive) else $error("bus not driven in read");
    property p_bus_release;
        rd_n && $past(rd_n) && $past(rd_n, 2) |-> !dev_data_oe;
    endproperty
    a_bus_release: assert property (p_bus_release) else $error("bus held after read");
    property p_no_fight;
        !(dev_data_oe && host_data_oe);
    endproperty
    a_no_fight: assert property (p_no_fight) else $error("both ends drive bus");
    property p_strobes_apart;
        !(!rd_n && wr);
    endproperty
    a_strobes_apart: assert property (p_strobes_apart) else $error("both strobes active");
    property p_rx_busy;
        $fell(rd_n) |=> rx_avail_n_out;
    endproperty
    a_rx_busy: assert property (p_rx_busy) else $error("rx flag low after read");
    property p_read_when_ready;
        $fell(rd_n) |-> !$past(rx_avail_n);
    endproperty
    a_read_when_ready: assert property (p_read_when_ready) else $error("read while empty");
    property p_read_width;
        $fell(rd_n) |-> (!rd_n)[*4] ##1 rd_n;
    endproperty
    a_read_width: assert property (p_read_width) else $error("read strobe width");
    property p_write_width;
        $rose(wr) |-> host_data_oe && $past(host_data_oe) ##0 wr[*4] ##1 !wr;
    endproperty
    a_write_width: assert property (p_write_width) else $error("write strobe shape");
    property p_write_hold;
        $fell(wr) |-> host_data_oe && $stable(fifo_byte_bus);
    endproperty
    a_write_hold: assert property (p_write_hold) else $error("write data moved");
    property p_flags_float;
        @(posedge clk_sys_i) disable iff (reset_i)
        !reset_n |=> !tx_room_n_oe && !rx_avail_n_oe && !dev_data_oe;
    endproperty
    a_flags_float: assert property (p_flags_float) else $error("flags driven in reset");
endmodule

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import fifo_port_pkg::*;
    typedef struct {byte_t din; byte_t dout;} row_t;
    logic  clk_sys_i = 1'b0, reset_i = 1'b1, rx_valid_i = 1'b0, tx_ready_i = 1'b1;
    logic  configured_i = 1'b1, suspend_i = 1'b0, pulldown_en_i = 1'b0;
    logic  wr_valid_i = 1'b0, dev_reset_i = 1'b0;
    logic  wakeup_en_i = 1'b0, wake_req_i = 1'b0, resume_req_o;
    logic  rx_ready_o, tx_valid_o, wr_ready_o, rd_valid_o, pulldown_o;
    byte_t rx_data_i = 8'h00, wr_data_i = 8'h00, tx_data_o, rd_data_o;
    byte_t txq[$], rdq[$];
    int    err_total = 0, samples_checked = 0;
    row_t  rows[6] = '{'{8'h00, 8'h00}, '{8'hFF, 8'hFF}, '{8'hA5, 8'hA5},
                       '{8'h5A, 8'h5A}, '{8'h01, 8'h01}, '{8'h80, 8'h80}};
    fifo_port_if port ();
    fifo_port_dev fifo_port_dev_i (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .port(port),
        .rx_data_i(rx_data_i), .rx_valid_i(rx_valid_i), .rx_ready_o(rx_ready_o),
        .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
        .configured_i(configured_i), .suspend_i(suspend_i), .wakeup_en_i(wakeup_en_i),
        .pulldown_en_i(pulldown_en_i), .resume_req_o(resume_req_o), .pulldown_o(pulldown_o));
    fifo_port_host fifo_port_host_i (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .port(port),
        .wr_data_i(wr_data_i), .wr_valid_i(wr_valid_i), .wr_ready_o(wr_ready_o),
        .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .wake_req_i(wake_req_i),
        .dev_reset_i(dev_reset_i));
    fifo_port_monitor fifo_port_monitor_i (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
        .fifo_byte_bus(port.fifo_byte_bus), .dev_data_oe(port.dev_data_oe),
        .host_data_oe(port.host_data_oe), .rd_n(port.rd_n), .wr(port.wr),
        .rx_avail_n(port.rx_avail_n), .rx_avail_n_out(port.rx_avail_n_out),
        .rx_avail_n_oe(port.rx_avail_n_oe), .tx_room_n_oe(port.tx_room_n_oe),
        .reset_n(port.reset_n));
    always #2.5 clk_sys_i = ~clk_sys_i;
    // ==========
    // Helpers
    // Sampling at the falling edge sees settled values ahead of the transfer edge
    always @(negedge clk_sys_i) begin
        if (tx_valid_o === 1'b1 && tx_ready_i === 1'b1) txq.push_back(tx_data_o);
        if (rd_valid_o === 1'b1) rdq.push_back(rd_data_o);
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic push_rx(input byte_t b);
        @(posedge clk_sys_i);
        rx_data_i  <= b;
        rx_valid_i <= 1'b1;
        do @(negedge clk_sys_i); while (rx_ready_o !== 1'b1);
        @(posedge clk_sys_i);
        rx_valid_i <= 1'b0;
    endtask
    task automatic push_wr(input byte_t b);
        @(posedge clk_sys_i);
        wr_data_i  <= b;
        wr_valid_i <= 1'b1;
        do @(negedge clk_sys_i); while (wr_ready_o !== 1'b1);
        @(posedge clk_sys_i);
        wr_valid_i <= 1'b0;
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ==========
    // Tests
    initial begin
        repeat (8) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        wait_cyc(40);
        chk("power enable", 8'h00, {7'h00, port.configured_power_n});
        chk("rx flag idle", 8'h01, {7'h00, port.rx_avail_n});
        foreach (rows[i]) push_rx(rows[i].din);
        foreach (rows[i]) push_wr(rows[i].din);
        wait_cyc(200);
        foreach (rows[i]) begin
            chk("read byte", rows[i].dout, rdq[i]);
            chk("written byte", rows[i].dout, txq[i]);
        end
        chk("read count", 8'h06, 8'(rdq.size()));
        chk("written count", 8'h06, 8'(txq.size()));
        $display("test rows done");
        // Stalled drain: host must hold the extra byte until room returns
        txq.delete();
        @(posedge clk_sys_i);
        tx_ready_i <= 1'b0;
        for (int i = 0; i < TX_DEPTH; i++) push_wr(8'(i));
        wait_cyc(20);
        chk("tx full flag", 8'h01, {7'h00, port.tx_room_n});
        chk("write ready when full", 8'h00, {7'h00, wr_ready_o});
        @(posedge clk_sys_i);
        tx_ready_i <= 1'b1;
        push_wr(8'hEE);
        wait_cyc(400);
        for (int i = 0; i < TX_DEPTH; i++) chk("drained byte", 8'(i), txq[i]);
        chk("byte after full", 8'hEE, txq[TX_DEPTH]);
        $display("test full done");
        @(posedge clk_sys_i);
        dev_reset_i <= 1'b1;
        wait_cyc(4);
        chk("flags in reset", 8'h00, {6'h00, port.tx_room_n_oe, port.rx_avail_n_oe});
        chk("power in reset", 8'h01, {7'h00, port.configured_power_n});
        @(posedge clk_sys_i);
        dev_reset_i <= 1'b0;
        rdq.delete();
        wait_cyc(40);
        chk("flags after reset", 8'h03, {6'h00, port.tx_room_n_oe, port.rx_avail_n_oe});
        push_rx(8'h3C);
        wait_cyc(40);
        chk("read after reset", 8'h3C, rdq[0]);
        $display("test reset done");
        @(posedge clk_sys_i);
        suspend_i     <= 1'b1;
        pulldown_en_i <= 1'b1;
        wait_cyc(10);
        chk("power in suspend", 8'h01, {7'h00, port.configured_power_n});
        chk("pull-down on", 8'h01, {7'h00, pulldown_o});
        @(posedge clk_sys_i);
        pulldown_en_i <= 1'b0;
        wait_cyc(10);
        chk("pull-down off", 8'h00, {7'h00, pulldown_o});
        @(posedge clk_sys_i);
        suspend_i <= 1'b0;
        wait_cyc(10);
        chk("power resumed", 8'h00, {7'h00, port.configured_power_n});
        $display("test suspend done");
        // The full wake pulse outlasts the run, so only its start is checked
        @(posedge clk_sys_i);
        suspend_i   <= 1'b1;
        wakeup_en_i <= 1'b1;
        wait_cyc(10);
        chk("rx flag released", 8'h00, {7'h00, port.rx_avail_n_oe});
        @(posedge clk_sys_i);
        wake_req_i <= 1'b1;
        wait_cyc(10);
        chk("wake pin low", 8'h00, {7'h00, port.rx_avail_n});
        chk("no early resume", 8'h00, {7'h00, resume_req_o});
        $display("test wake done");
        test_done();
    end
    // Longest path is the stalled fill, a few thousand cycles
    initial begin
        repeat (30000) @(posedge clk_sys_i);
        err_total++;
        test_done();
    end
endmodule
